// *** fvp_defines.svh ***
// Constants for the nonvolatile memory control and vector page block
`ifndef FVP_DEFINES_SVH
`define FVP_DEFINES_SVH
`define FVP_IDX_CTRL      16'hFE08
`define FVP_IDX_BPR       16'hFFBE
`define FVP_IDX_TRIM      16'hFFC0
`define FVP_IDX_WDOG      16'hFFFF
`define FVP_IDX_W         16
`define FVP_BIT_HIGH_VOLTAGE_ON      3
`define FVP_BIT_MASS      2
`define FVP_BIT_ERASE     1
`define FVP_BIT_PGM       0
`define FVP_CTRL_W        4
`define FVP_PAGE_BYTES    64
`define FVP_ROW_BYTES     32
`define FVP_ARRAY_BYTES   256
`define FVP_ERASED        8'hFF
`define FVP_BPR_NONE      8'hFF
`define FVP_PROT_SHIFT    7
`define FVP_VEC_TOP       16'hFFFE
`define FVP_VEC_LAST      5'h10
`define FVP_TRIM_FACTORY  8'h80
`define FVP_SECURE_FILL   8'h00
`define FVP_HSIZE_WORD    3'b010
`endif

// *** fvp_pkg.sv ***
// Types for the nonvolatile memory control and vector page block
package fvp_pkg;
    typedef enum logic [2:0] {
        FVP_SEQ_IDLE    = 3'b000,
        FVP_SEQ_ARMED   = 3'b001,
        FVP_SEQ_CHECKED = 3'b010,
        FVP_SEQ_LATCHED = 3'b011,
        FVP_SEQ_HIGHV   = 3'b100
    } fvp_seq_t;
endpackage

// *** fvp_nvm_array.sv ***
// Nonvolatile array at the top of the map with program and erase ports
`timescale 1ns/1ps
`include "fvp_defines.svh"
module fvp_nvm_array #(
    parameter int       DEPTH       = `FVP_ARRAY_BYTES,
    parameter int       PAGE        = `FVP_PAGE_BYTES,
    parameter bit [7:0] TRIM_INIT   = `FVP_TRIM_FACTORY
) (
    input  wire logic        hclk,
    input  wire logic [15:0] rd_addr,
    output logic      [7:0]  rd_data,
    input  wire logic [15:0] vec_addr,
    output logic      [15:0] vec_data,
    output logic      [7:0]  trim_byte,
    output logic      [7:0]  bpr_byte,
    input  wire logic        prog_en,
    input  wire logic [15:0] prog_addr,
    input  wire logic [7:0]  prog_data,
    input  wire logic        erase_en,
    input  wire logic        erase_mass,
    input  wire logic [15:0] erase_addr
);
    localparam int IW = $clog2(DEPTH);
    localparam int PW = $clog2(PAGE);

    initial begin
        if (DEPTH < 128 || DEPTH > 32768 || (1 << IW) != DEPTH)
            $error("fvp_nvm_array: DEPTH must be a power of two, 128..32768");
    end

    logic [7:0] mem [DEPTH];

    // Factory image: erased array holding the trim value
    initial begin
        for (int i = 0; i < DEPTH; i++) begin
            mem[i] = `FVP_ERASED;
        end
        mem[`FVP_IDX_TRIM - (17'h10000 - DEPTH)] = TRIM_INIT;
    end

    function automatic logic [IW-1:0] idx(input logic [15:0] a);
        return a[IW-1:0];
    endfunction

    function automatic logic in_array(input logic [15:0] a);
        return a >= 16'(17'h10000 - DEPTH);
    endfunction

    always_comb begin
        rd_data   = in_array(rd_addr) ? mem[idx(rd_addr)] : `FVP_ERASED;
        vec_data  = {mem[idx(vec_addr)], mem[idx(vec_addr + 16'h0001)]};
        trim_byte = mem[idx(`FVP_IDX_TRIM)];
        bpr_byte  = mem[idx(`FVP_IDX_BPR)];
    end

    // Erase sets ones, program only clears bits
    always @(posedge hclk) begin
        if (erase_en) begin
            for (int i = 0; i < DEPTH; i++) begin
                if (erase_mass || i[IW-1:PW] == erase_addr[IW-1:PW]) begin
                    mem[i] <= `FVP_ERASED;
                end
            end
        end else if (prog_en && in_array(prog_addr)) begin
            mem[idx(prog_addr)] <= mem[idx(prog_addr)] & prog_data;
        end
    end
endmodule

// *** fvp_nvm_ctrl.sv ***
// Memory control register, protection, trim, watchdog and vector fetch
`timescale 1ns/1ps
`include "fvp_defines.svh"
module fvp_nvm_ctrl #(
    parameter int       DEPTH     = `FVP_ARRAY_BYTES,
    parameter bit [7:0] TRIM_INIT = `FVP_TRIM_FACTORY
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata_q,
    output logic             hreadyout_q,
    output logic             hresp_q,
    input  wire logic        monitor_mode,
    input  wire logic        monitor_unlocked,
    input  wire logic        vector_req,
    input  wire logic [4:0]  vector_sel,
    output logic             vector_valid_q,
    output logic             vector_hit_q,
    output logic      [15:0] vector_q,
    output logic      [7:0]  osc_adjust_q,
    output logic             watchdog_clear_q,
    output logic             high_voltage_q
);
    initial begin
        if (DEPTH < 128 || DEPTH > 32768 || (DEPTH & (DEPTH - 1)) != 0)
            $error("fvp_nvm_ctrl: DEPTH must be a power of two, 128..32768");
    end

    // Bus address phase capture
    logic                  wr_pend_q;
    logic                  rd_pend_q;
    logic [15:0]           dp_idx_q;
    logic                  take;
    logic [15:0]           ap_idx;

    // Control state
    logic                  high_voltage_on_q;
    logic                  whole_array_q;
    logic                  erase_sel_q;
    logic                  row_write_select_q;
    fvp_pkg::fvp_seq_t     seq_q;
    logic [15:0]           target_q;
    logic                  boot_q;

    // Array ports
    logic [7:0]            arr_rd;
    logic [15:0]           arr_vec;
    logic [7:0]            arr_trim;
    logic [7:0]            protect_boundary;
    logic                  prog_en;
    logic                  erase_en;
    logic [15:0]           vec_addr;

    // Write decode
    logic                  wr_ctrl;
    logic                  wr_trim;
    logic                  wr_wdog;
    logic                  wr_array;
    logic [`FVP_CTRL_W-1:0] ctrl_new;
    logic                  hv_ok;

    assign take   = hsel && htrans[1] && hready;
    assign ap_idx = haddr[17:2];

    function automatic logic in_window(input logic [15:0] a);
        return a >= 16'(17'h10000 - DEPTH);
    endfunction

    function automatic logic is_protected(input logic [15:0] a, input logic [7:0] b);
        return (b != `FVP_BPR_NONE) && (a >= 16'({1'b1, b} << `FVP_PROT_SHIFT));
    endfunction

    function automatic logic [15:0] vec_slot(input logic [4:0] n);
        return `FVP_VEC_TOP - {10'h000, n, 1'b0};
    endfunction

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            dp_idx_q  <= 16'h0000;
        end else begin
            if (take) begin
                wr_pend_q <= hwrite;
                rd_pend_q <= !hwrite;
                dp_idx_q  <= ap_idx;
            end else begin
                wr_pend_q <= 1'b0;
                if (rd_pend_q) begin
                    rd_pend_q <= 1'b0;
                end
            end
        end
    end

    // One wait state on reads so read data comes from a flop
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout_q <= 1'b1;
        end else if (take && !hwrite) begin
            hreadyout_q <= 1'b0;
        end else begin
            hreadyout_q <= 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hresp_q <= 1'b0;
        end else begin
            hresp_q <= 1'b0;
        end
    end

    always_comb begin
        wr_ctrl  = wr_pend_q && dp_idx_q == `FVP_IDX_CTRL;
        wr_trim  = wr_pend_q && dp_idx_q == `FVP_IDX_TRIM && seq_q == fvp_pkg::FVP_SEQ_IDLE;
        wr_wdog  = wr_pend_q && dp_idx_q == `FVP_IDX_WDOG && !high_voltage_on_q;
        wr_array = wr_pend_q && in_window(dp_idx_q);
        ctrl_new = hwdata[`FVP_CTRL_W-1:0];
        hv_ok    = seq_q == fvp_pkg::FVP_SEQ_LATCHED
                   && (row_write_select_q || erase_sel_q)
                   && !is_protected(target_q, protect_boundary)
                   && !(whole_array_q && erase_sel_q && protect_boundary != `FVP_BPR_NONE);
        // Program only inside the latched row
        prog_en  = wr_array && seq_q == fvp_pkg::FVP_SEQ_HIGHV && row_write_select_q
                   && dp_idx_q[15:$clog2(`FVP_ROW_BYTES)]
                      == target_q[15:$clog2(`FVP_ROW_BYTES)];
        // Erase starts as high voltage comes on
        erase_en = wr_ctrl && ctrl_new[`FVP_BIT_HIGH_VOLTAGE_ON] && !high_voltage_on_q
                   && hv_ok && erase_sel_q;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            high_voltage_on_q  <= 1'b0;
            whole_array_q      <= 1'b0;
            erase_sel_q        <= 1'b0;
            row_write_select_q <= 1'b0;
        end else if (wr_ctrl) begin
            whole_array_q <= ctrl_new[`FVP_BIT_MASS];
            if (!(ctrl_new[`FVP_BIT_ERASE] && ctrl_new[`FVP_BIT_PGM])) begin
                erase_sel_q        <= ctrl_new[`FVP_BIT_ERASE];
                row_write_select_q <= ctrl_new[`FVP_BIT_PGM];
            end
            // High voltage set only when allowed
            if (!ctrl_new[`FVP_BIT_HIGH_VOLTAGE_ON]) begin
                high_voltage_on_q <= 1'b0;
            end else if (hv_ok || high_voltage_on_q) begin
                high_voltage_on_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            seq_q    <= fvp_pkg::FVP_SEQ_IDLE;
            target_q <= 16'h0000;
        end else begin
            case (seq_q)
                fvp_pkg::FVP_SEQ_IDLE: begin
                    if (wr_ctrl && (ctrl_new[`FVP_BIT_ERASE] ^ ctrl_new[`FVP_BIT_PGM])) begin
                        seq_q <= fvp_pkg::FVP_SEQ_ARMED;
                    end
                end
                fvp_pkg::FVP_SEQ_ARMED: begin
                    if (rd_pend_q && dp_idx_q == `FVP_IDX_BPR) begin
                        seq_q <= fvp_pkg::FVP_SEQ_CHECKED;
                    end
                end
                fvp_pkg::FVP_SEQ_CHECKED: begin
                    if (wr_array) begin
                        seq_q    <= fvp_pkg::FVP_SEQ_LATCHED;
                        target_q <= dp_idx_q;
                    end
                end
                fvp_pkg::FVP_SEQ_LATCHED: begin
                    if (erase_en || (wr_ctrl && ctrl_new[`FVP_BIT_HIGH_VOLTAGE_ON] && hv_ok)) begin
                        seq_q <= fvp_pkg::FVP_SEQ_HIGHV;
                    end
                end
                fvp_pkg::FVP_SEQ_HIGHV: begin
                    if (wr_ctrl && !ctrl_new[`FVP_BIT_HIGH_VOLTAGE_ON]) begin
                        seq_q <= fvp_pkg::FVP_SEQ_LATCHED;
                    end
                end
                default: begin
                    seq_q <= fvp_pkg::FVP_SEQ_IDLE;
                end
            endcase
            if (wr_ctrl && !ctrl_new[`FVP_BIT_ERASE] && !ctrl_new[`FVP_BIT_PGM]
                && !ctrl_new[`FVP_BIT_HIGH_VOLTAGE_ON]) begin
                seq_q <= fvp_pkg::FVP_SEQ_IDLE;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            high_voltage_q <= 1'b0;
        end else begin
            high_voltage_q <= high_voltage_on_q;
        end
    end

    // Trim taken from the factory byte after reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            boot_q       <= 1'b1;
            osc_adjust_q <= 8'h00;
        end else if (boot_q) begin
            boot_q       <= 1'b0;
            osc_adjust_q <= arr_trim;
        end else if (wr_trim) begin
            osc_adjust_q <= hwdata[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            watchdog_clear_q <= 1'b0;
        end else begin
            watchdog_clear_q <= wr_wdog;
        end
    end

    // Read data, taken at the end of the wait state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= 32'h0000_0000;
        end else if (rd_pend_q) begin
            if (dp_idx_q == `FVP_IDX_CTRL) begin
                hrdata_q <= {28'h000_0000, high_voltage_on_q, whole_array_q,
                             erase_sel_q, row_write_select_q};
            end else if (dp_idx_q == `FVP_IDX_TRIM) begin
                hrdata_q <= {24'h00_0000, osc_adjust_q};
            end else if (in_window(dp_idx_q)) begin
                // Secured monitor reads see fill only
                // Watchdog location reads the vector byte
                hrdata_q <= {24'h00_0000, (monitor_mode && !monitor_unlocked)
                                          ? `FVP_SECURE_FILL : arr_rd};
            end else begin
                hrdata_q <= 32'h0000_0000;
            end
        end
    end

    // Flag slots descend, none past sixteen
    assign vec_addr = vec_slot(vector_sel);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            vector_valid_q <= 1'b0;
            vector_hit_q   <= 1'b0;
            vector_q       <= 16'h0000;
        end else begin
            vector_valid_q <= vector_req;
            if (vector_req) begin
                vector_hit_q <= vector_sel <= `FVP_VEC_LAST;
                vector_q     <= (vector_sel <= `FVP_VEC_LAST) ? arr_vec : 16'h0000;
            end
        end
    end

    fvp_nvm_array #(
        .DEPTH      (DEPTH),
        .PAGE       (`FVP_PAGE_BYTES),
        .TRIM_INIT  (TRIM_INIT)
    ) u_array (
        .hclk       (hclk),
        .rd_addr    (dp_idx_q),
        .rd_data    (arr_rd),
        .vec_addr   (vec_addr),
        .vec_data   (arr_vec),
        .trim_byte  (arr_trim),
        .bpr_byte   (protect_boundary),
        .prog_en    (prog_en),
        .prog_addr  (dp_idx_q),
        .prog_data  (hwdata[7:0]),
        .erase_en   (erase_en),
        .erase_mass (whole_array_q && protect_boundary == `FVP_BPR_NONE),
        .erase_addr (target_q)
    );
endmodule

// *** fvp_nvm_ctrl_props.sv ***
// Port checks for the memory control block
`timescale 1ns/1ps
module fvp_nvm_ctrl_props (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata_q,
    input wire logic        hreadyout_q,
    input wire logic        monitor_mode,
    input wire logic        monitor_unlocked,
    input wire logic        vector_req,
    input wire logic [4:0]  vector_sel,
    input wire logic        vector_valid_q,
    input wire logic        vector_hit_q,
    input wire logic [15:0] vector_q,
    input wire logic        watchdog_clear_q,
    input wire logic        high_voltage_q
);
    logic take;
    logic rd_ctl;
    logic ctl_wr_q;
    logic wd_wr_q;
    assign take   = hsel && htrans[1] && hready;
    assign rd_ctl = take && !hwrite && haddr[17:2] == 16'hFE08;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctl_wr_q <= 1'b0;
            wd_wr_q  <= 1'b0;
        end else begin
            ctl_wr_q <= take && hwrite && haddr[17:2] == 16'hFE08;
            wd_wr_q  <= take && hwrite && haddr[17:2] == 16'hFFFF;
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_read_one_wait: assert property (
        take && !hwrite |=> !hreadyout_q ##1 hreadyout_q) else $error("read wait wrong");
    a_ctrl_upper_zero: assert property (
        rd_ctl |-> ##2 hrdata_q[7:4] == 4'h0) else $error("control upper bits set");
    a_select_interlock: assert property (
        rd_ctl |-> ##2 !(hrdata_q[1] && hrdata_q[0])) else $error("erase and program both set");
    a_hv_after_write: assert property (
        $rose(high_voltage_q) |-> $past(ctl_wr_q) || $past(ctl_wr_q, 2) || $past(ctl_wr_q, 3))
        else $error("high voltage without control write");
    a_vector_answer: assert property (
        vector_req |=> vector_valid_q && vector_hit_q == ($past(vector_sel) <= 5'h10))
        else $error("vector answer wrong");
    a_no_slot_zero: assert property (
        vector_req && vector_sel > 5'h10 |=> vector_q == 16'h0000) else $error("unused slot");
    a_monitor_hidden: assert property (
        take && !hwrite && haddr[17:2] >= 16'hFF00 && monitor_mode && !monitor_unlocked
        |-> ##2 hrdata_q == 32'h0000_0000) else $error("secured read visible");
    a_wdog_one_pulse: assert property (
        watchdog_clear_q |-> $past(wd_wr_q) ##1 !watchdog_clear_q) else $error("clear pulse wrong");
    cover property (rd_ctl);
    cover property ($rose(high_voltage_q));
    cover property (watchdog_clear_q);
endmodule
bind fvp_nvm_ctrl fvp_nvm_ctrl_props u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata_q(hrdata_q),
    .hreadyout_q(hreadyout_q), .monitor_mode(monitor_mode), .monitor_unlocked(monitor_unlocked),
    .vector_req(vector_req), .vector_sel(vector_sel), .vector_valid_q(vector_valid_q),
    .vector_hit_q(vector_hit_q), .vector_q(vector_q), .watchdog_clear_q(watchdog_clear_q),
    .high_voltage_q(high_voltage_q));

// *** fvp_bus_master.sv ***
// Processor-side bus master model for single word transfers
`timescale 1ns/1ps
module fvp_bus_master (
    input  wire logic        hclk,
    output logic             hsel,
    output logic      [31:0] haddr,
    output logic      [1:0]  htrans,
    output logic             hwrite,
    output logic      [2:0]  hsize,
    output logic      [31:0] hwdata,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata
);
    logic hung = 1'b0;
    initial begin
        hsel   = 1'b0;
        haddr  = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize  = 3'h2;
        hwdata = 32'h0000_0000;
    end
    // Entered just after a rising edge; holds each phase until ready
    task automatic xfer(input logic wr, input logic [15:0] idx, input logic [7:0] wd,
                        output logic [7:0] rd);
        int n;
        hsel   <= 1'b1;
        haddr  <= {14'h0000, idx, 2'h0};
        htrans <= 2'h2;
        hwrite <= wr;
        hwdata <= ~hwdata;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (!hready && n < 50);
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= {24'h00_0000, wd};
        do begin
            @(posedge hclk);
            n++;
        end while (!hready && n < 100);
        rd = hrdata[7:0];
        if (n >= 50) hung = 1'b1;
    endtask
endmodule

// *** fvp_nvm_ctrl_test.sv ***
// Self-checking bench for the memory control block
`timescale 1ns/1ps
module fvp_nvm_ctrl_test;
    logic        hclk, hresetn = 1'b0, hsel, hwrite, hready, vvalid, vhit, wdc, hv, hresp;
    logic        mon = 1'b0, unl = 1'b0, vreq = 1'b0;
    logic [4:0]  vsel = 5'h00;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [15:0] vq, slot, ev;
    logic [7:0]  osc, rv;
    int          fails = 0, compares = 0, n;
    logic [24:0] rows [12] = '{25'h0FE_0800, 25'h1FE_0803, 25'h0FE_0800, 25'h1FE_080C,
        25'h0FE_0804, 25'h1FE_0800, 25'h0FF_FFFF, 25'h010_0000, 25'h0FF_BEFF, 25'h0FF_C080,
        25'h1FF_C05A, 25'h0FF_C05A};
    fvp_bus_master bm (.hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata));
    fvp_nvm_ctrl DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata_q(hrdata), .hreadyout_q(hready), .hresp_q(hresp), .monitor_mode(mon),
        .monitor_unlocked(unl), .vector_req(vreq), .vector_sel(vsel), .vector_valid_q(vvalid),
        .vector_hit_q(vhit), .vector_q(vq), .osc_adjust_q(osc), .watchdog_clear_q(wdc),
        .high_voltage_q(hv));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic conclude;
        if (bm.hung) fails++;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        bm.xfer(1'b1, a, d, rv);
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        bm.xfer(1'b0, a, 8'h00, rv);
        chk({a[6:0], hresp, rv}, {a[6:0], 1'b0, e}, "read data");
    endtask
    task automatic hvis(input logic e);
        chk({15'h0000, hv}, {15'h0000, e}, "high voltage");
    endtask
    task automatic seq(input logic [7:0] sel, input logic [15:0] a);
        wr(16'hFE08, sel);
        bm.xfer(1'b0, 16'hFFBE, 8'h00, rv);
        wr(a, 8'h00);
        wr(16'hFE08, sel | 8'h08);
        repeat (2) @(posedge hclk);
    endtask
    task automatic rst;
        hresetn <= 1'b0;
        repeat (8) @(posedge hclk);
        hvis(1'b0);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        chk({8'h00, osc}, 16'h0080, "trim");
    endtask
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    // Ends the run on the cycle limit or as soon as the master gives up waiting
    initial begin
        for (int c = 0; c < 30000 && !bm.hung; c++) begin
            @(posedge hclk);
        end
        fails++;
        conclude();
    end
    initial begin
        rst();
        for (int i = 0; i < 12; i++) begin
            if (rows[i][24]) wr(rows[i][23:8], rows[i][7:0]);
            else rd(rows[i][23:8], rows[i][7:0]);
        end
        chk({8'h00, osc}, 16'h005A, "trim write");
        seq(8'h01, 16'hFF80);
        hvis(1'b1);
        wr(16'hFF81, 8'hA5);
        wr(16'hFFA0, 8'h00);
        wr(16'hFE08, 8'h00);
        rd(16'hFF81, 8'hA5);
        rd(16'hFFA0, 8'hFF);
        seq(8'h01, 16'hFF60);
        wr(16'hFF7F, 8'h3C);
        wr(16'hFE08, 8'h00);
        seq(8'h02, 16'hFF85);
        wr(16'hFE08, 8'h00);
        rd(16'hFF81, 8'hFF);
        rd(16'hFF7F, 8'h3C);
        wr(16'hFE08, 8'h02);
        wr(16'hFF85, 8'h00);
        wr(16'hFE08, 8'h0A);
        repeat (2) @(posedge hclk);
        hvis(1'b0);
        wr(16'hFE08, 8'h00);
        seq(8'h01, 16'hFFE0);
        for (logic [15:0] a = 16'hFFE0; a != 16'hFFFF; a++) wr(a, a[7:0]);
        wr(16'hFE08, 8'h00);
        for (int k = 0; k < 21; k++) begin
            slot = 16'hFFFE - 16'(2 * k);
            vreq <= 1'b1;
            vsel <= 5'(k);
            @(posedge hclk);
            vreq <= 1'b0;
            #1;
            ev = (k > 16) ? 16'h0000 : (slot >= 16'hFFE0) ? {slot[7:0], slot[7:0] + 8'h01} : 16'hFFFF;
            chk({14'h0000, vvalid, vhit}, {14'h0000, 1'b1, k <= 16}, "vector flags");
            chk(vq, ev, "vector");
            @(posedge hclk);
        end
        wr(16'hFFFF, 8'h00);
        n = 0;
        repeat (3) begin
            #1;
            if (wdc === 1'b1) n++;
            @(posedge hclk);
        end
        chk(16'(n), 16'h0001, "clear pulses");
        rd(16'hFFFF, 8'hFF);
        mon <= 1'b1;
        rd(16'hFF7F, 8'h00);
        unl <= 1'b1;
        rd(16'hFF7F, 8'h3C);
        mon <= 1'b0;
        unl <= 1'b0;
        rst();
        seq(8'h01, 16'hFFBE);
        wr(16'hFFBE, 8'hFE);
        wr(16'hFE08, 8'h00);
        rd(16'hFFBE, 8'hFE);
        seq(8'h01, 16'hFF80);
        hvis(1'b0);
        wr(16'hFE08, 8'h00);
        seq(8'h06, 16'hFF80);
        hvis(1'b0);
        conclude();
    end
endmodule
